// ==== logic/ufc_top.sv ====
// Purpose: uart fifo control, low interrupt enables and dma request pins
// Assumes: receiver, transmitter and timeout logic share pclk
// Notes: registers sit behind apb with one wait state
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.svh"
module ufc_top
  import ufc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receive shifter side
  input  wire logic        rx_push,
  input  wire logic [7:0]  rx_data,
  input  wire logic [2:0]  rx_err,
  input  wire logic        rx_timeout,
  // transmit shifter side
  input  wire logic        tx_take,
  input  wire logic        tx_shift_empty,
  output logic [7:0]       tx_data,
  output logic             tx_avail,
  // pins
  output logic             tx_dma_request_n,
  output logic             rx_dma_request_n,
  output logic             irq
);
  ufc_fifo_if rxq ();
  ufc_fifo_if txq ();

  logic [2:0]  interrupt_enable_r;
  logic        fifo_en_r;
  ufc_dma_e    dma_mode_r;
  logic [1:0]  trig_sel_r;
  logic [3:0]  err_r;
  logic        ls_pend_r;
  ufc_rxq_e    rxq_st_r;
  ufc_rxq_e    rxq_st_nxt;
  logic        wr_stb;
  logic        rd_stb;
  logic        map_ok;
  logic [31:0] rd_data;
  logic        wr_fc;
  logic        rx_flush;
  logic        tx_flush;
  logic        ls_rd;
  ufc_cnt_t    cap;
  ufc_cnt_t    trig;
  logic        rx_full;
  logic        tx_full;
  logic        at_trig;
  logic        data_ready;
  logic        tx_empty;
  logic        ls_int;
  logic        rx_int;
  logic        tx_int;
  logic        mode_blk;
  logic [7:0]  line_status;
  logic [7:0]  interrupt_status;
  logic [7:0]  fifo_control;

  // trigger code to byte count
  function automatic ufc_cnt_t trig_level(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_level = `UFC_TRIG_1;
      2'h1:    trig_level = `UFC_TRIG_4;
      2'h2:    trig_level = `UFC_TRIG_8;
      default: trig_level = `UFC_TRIG_14;
    endcase
  endfunction

  // address match for one register
  function automatic logic hit(input ufc_addr_t a, input ufc_addr_t off);
    hit = (a == off);
  endfunction

  // bus slave timing
  ufc_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .rd_data (rd_data),
    .map_ok  (map_ok),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb)
  );

  // receive and transmit queues
  ufc_fifo u_rxq (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .q       (rxq)
  );

  ufc_fifo u_txq (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .q       (txq)
  );

  // address map
  assign map_ok = hit(paddr, `UFC_OFF_DATA) || hit(paddr, `UFC_OFF_IE) ||
                  hit(paddr, `UFC_OFF_FC) || hit(paddr, `UFC_OFF_IS) ||
                  hit(paddr, `UFC_OFF_LS);

  // write and read side effects
  assign wr_fc    = wr_stb && hit(paddr, `UFC_OFF_FC);
  assign rx_flush = wr_fc && pwdata[`UFC_FC_EN] &&
                    pwdata[`UFC_FC_RXCLR];
  assign tx_flush = wr_fc && pwdata[`UFC_FC_EN] &&
                    pwdata[`UFC_FC_TXCLR];
  assign ls_rd    = rd_stb && hit(paddr, `UFC_OFF_LS);

  // capacity: one holding slot without fifos, sixteen with them
  assign cap      = fifo_en_r ? `UFC_DEPTH : 5'h01;
  assign rx_full  = rxq.count >= cap;
  assign tx_full  = txq.count >= cap;
  assign trig     = trig_level(trig_sel_r);
  assign at_trig  = rxq.count >= trig;
  assign data_ready = rxq.count != 5'h00;
  assign tx_empty = txq.count == 5'h00;
  assign mode_blk = fifo_en_r && (dma_mode_r == UFC_DMA_BLOCK);

  // receive queue control, filling goes on past trigger
  assign rxq.push  = rx_push && !rx_full && !rx_flush;
  assign rxq.wdata = rx_data;
  assign rxq.pop   = rd_stb && hit(paddr, `UFC_OFF_DATA);
  assign rxq.flush = rx_flush;

  // transmit queue control
  assign txq.push  = wr_stb && hit(paddr, `UFC_OFF_DATA) && !tx_full &&
                     !tx_flush;
  assign txq.wdata = pwdata[7:0];
  assign txq.pop   = tx_take && tx_avail;
  assign txq.flush = tx_flush;

  // interrupt enable, low three bits only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_r <= `UFC_IE_RST;
    end else if (ce && wr_stb && hit(paddr, `UFC_OFF_IE)) begin
      interrupt_enable_r <= pwdata[2:0];
    end
  end

  // fifo control: other bits taken only with enable set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_en_r  <= 1'b0;
      dma_mode_r <= UFC_DMA_SINGLE;
      trig_sel_r <= `UFC_TRIG_RST;
    end else if (ce && wr_fc) begin
      fifo_en_r <= pwdata[`UFC_FC_EN];
      if (pwdata[`UFC_FC_EN]) begin
        dma_mode_r <= pwdata[`UFC_FC_DMA] ? UFC_DMA_BLOCK : UFC_DMA_SINGLE;
        trig_sel_r <= pwdata[`UFC_FC_TRIG+1:`UFC_FC_TRIG];
      end
    end
  end

  // receive error flags, a new error beats the read that clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 4'h0;
    end else if (ce) begin
      err_r <= (ls_rd ? 4'h0 : err_r) |
               {rx_push ? rx_err : 3'h0, rx_push && rx_full};
    end
  end

  // arrival event for line status interrupt, set wins over read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_pend_r <= 1'b0;
    end else if (ce) begin
      ls_pend_r <= (ls_pend_r && !ls_rd) || rxq.push;
    end
  end

  // interrupt sources
  assign ls_int = interrupt_enable_r[2] && ls_pend_r;
  assign tx_int = interrupt_enable_r[1] && tx_empty;
  assign rx_int = interrupt_enable_r[0] &&
                  (fifo_en_r ? (at_trig || rx_timeout)
                             : data_ready);

  // status views
  assign line_status = {fifo_en_r && (err_r != 4'h0),
                        tx_empty && tx_shift_empty,
                        tx_empty,
                        err_r,
                        data_ready};
  assign fifo_control = {trig_sel_r, 2'h0, dma_mode_r == UFC_DMA_BLOCK,
                         2'h0, fifo_en_r};

  // interrupt status, highest pending source
  always_comb begin
    interrupt_status = {{2{fifo_en_r}}, 2'h0, `UFC_IS_NONE};
    if (ls_int) begin
      interrupt_status[3:0] = `UFC_IS_LS;
    end else if (rx_int) begin
      interrupt_status[3:0] = (fifo_en_r && !at_trig) ?
                              `UFC_IS_TO : `UFC_IS_RX;
    end else if (tx_int) begin
      interrupt_status[3:0] = `UFC_IS_TX;
    end
  end

  // read data mux
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(paddr, `UFC_OFF_DATA)) rd_data[7:0] = rxq.rdata;
    if (hit(paddr, `UFC_OFF_IE)) rd_data[2:0] = interrupt_enable_r;
    if (hit(paddr, `UFC_OFF_FC)) rd_data[7:0] = fifo_control;
    if (hit(paddr, `UFC_OFF_IS)) rd_data[7:0] = interrupt_status;
    if (hit(paddr, `UFC_OFF_LS)) rd_data[7:0] = line_status;
  end

  // block mode receive request state
  always_comb begin
    rxq_st_nxt = rxq_st_r;
    case (rxq_st_r)
      UFC_RXQ_IDLE: begin
        if (at_trig || rx_timeout) rxq_st_nxt = UFC_RXQ_HELD;
      end
      UFC_RXQ_HELD: begin
        if (!data_ready) rxq_st_nxt = UFC_RXQ_IDLE;
      end
      default: rxq_st_nxt = UFC_RXQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxq_st_r <= UFC_RXQ_IDLE;
    end else if (ce) begin
      rxq_st_r <= rxq_st_nxt;
    end
  end

  // registered pins and interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dma_request_n <= 1'b0;
      rx_dma_request_n <= 1'b1;
      irq              <= 1'b0;
    end else if (ce) begin
      tx_dma_request_n <= mode_blk ? (txq.count == `UFC_DEPTH)
                                   : !tx_empty;
      rx_dma_request_n <= mode_blk ? (rxq_st_nxt != UFC_RXQ_HELD)
                                   : !data_ready;
      irq              <= ls_int || rx_int || tx_int;
    end
  end

  // head byte to transmit shifter, gap of one cycle after each take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data  <= 8'h00;
      tx_avail <= 1'b0;
    end else if (ce) begin
      tx_data  <= txq.rdata;
      tx_avail <= !tx_empty && !txq.pop && !tx_flush;
    end
  end

  // checks
  default clocking ck @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  sequence s_arrive;
    rxq.push && interrupt_enable_r[2];
  endsequence

  sequence s_blk_trig;
    mode_blk && (at_trig || rx_timeout);
  endsequence

  a_ie_reset_zero: assert property (
    $rose(presetn) |-> interrupt_enable_r == 3'h0)
    else $error("interrupt enables not zero after reset");

  a_arrival_irq: assert property (
    s_arrive |=> ls_pend_r ##1 irq)
    else $error("arrival did not raise interrupt");

  a_tx_empty_irq: assert property (
    interrupt_enable_r[1] && tx_empty |=> irq)
    else $error("empty holding did not raise interrupt");

  a_trig_irq: assert property (
    interrupt_enable_r == 3'h1 && fifo_en_r && !at_trig && !rx_timeout
    |=> !irq)
    else $error("receive interrupt below trigger");

  a_trig_status: assert property (
    fifo_en_r && rx_int && at_trig && !ls_int
    |-> interrupt_status[3:0] == `UFC_IS_RX)
    else $error("trigger not shown in interrupt status");

  a_data_ready: assert property (
    rxq.push |=> line_status[0])
    else $error("data ready not set after arrival");

  a_fill_past_trig: assert property (
    fifo_en_r && rx_push && at_trig && rxq.count < `UFC_DEPTH &&
    !rx_flush |=> rxq.count == $past(rxq.count) + 5'h01)
    else $error("character refused before full");

  a_tx_req_blk: assert property (
    mode_blk && txq.count == `UFC_DEPTH |=> tx_dma_request_n)
    else $error("block transmit request not high when full");

  a_tx_req_single: assert property (
    !mode_blk && tx_empty |=> !tx_dma_request_n)
    else $error("single transmit request not low when empty");

  a_rx_req_hold: assert property (
    s_blk_trig ##1 (mode_blk && data_ready) |-> !rx_dma_request_n)
    else $error("block receive request not held low");

  a_fc_ignored: assert property (
    wr_fc && !pwdata[`UFC_FC_EN] |=> $stable(trig_sel_r) &&
    $stable(dma_mode_r) && !fifo_en_r)
    else $error("control bits changed without enable");

  a_dma_default: assert property (
    $rose(presetn) |-> dma_mode_r == UFC_DMA_SINGLE && !fifo_en_r)
    else $error("dma mode or fifo enable not reset");

  a_tx_flush: assert property (
    tx_flush |=> txq.count == 5'h00 && !tx_avail)
    else $error("transmit flush left data");
endmodule
`default_nettype wire

// ==== logic/ufc_defines.svh ====
// Purpose: constants for the uart fifo, interrupt and dma control block
// Assumes: one clock, 32-bit apb register access, 16-entry fifos
// Notes: offsets are byte addresses, one aligned word each
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH
`define UFC_DEPTH      5'h10
`define UFC_OFF_DATA   12'h000
`define UFC_OFF_IE     12'h004
`define UFC_OFF_FC     12'h008
`define UFC_OFF_IS     12'h00C
`define UFC_OFF_LS     12'h010
`define UFC_IE_RST     3'h0
`define UFC_TRIG_RST   2'h0
`define UFC_FC_EN      0
`define UFC_FC_RXCLR   1
`define UFC_FC_TXCLR   2
`define UFC_FC_DMA     3
`define UFC_FC_TRIG    6
`define UFC_TRIG_1     5'h01
`define UFC_TRIG_4     5'h04
`define UFC_TRIG_8     5'h08
`define UFC_TRIG_14    5'h0E
`define UFC_IS_NONE    4'h1
`define UFC_IS_LS      4'h6
`define UFC_IS_RX      4'h4
`define UFC_IS_TO      4'hC
`define UFC_IS_TX      4'h2
`endif

// ==== logic/ufc_pkg.sv ====
// Purpose: types shared by the uart fifo control block
// Assumes: constants live in ufc_defines.svh
// Notes: none
package ufc_pkg;
  typedef enum logic {UFC_DMA_SINGLE, UFC_DMA_BLOCK} ufc_dma_e;
  typedef enum logic {UFC_RXQ_IDLE, UFC_RXQ_HELD} ufc_rxq_e;
  typedef logic [7:0]  ufc_byte_t;
  typedef logic [4:0]  ufc_cnt_t;
  typedef logic [11:0] ufc_addr_t;
endpackage

// ==== logic/ufc_fifo_if.sv ====
// Purpose: signals between the control core and one byte fifo
// Assumes: same clock on both sides
// Notes: push beyond full and pop when empty are dropped
`timescale 1ns/1ps
`default_nettype none
interface ufc_fifo_if;
  import ufc_pkg::*;
  logic      push;
  ufc_byte_t wdata;
  logic      pop;
  logic      flush;
  ufc_byte_t rdata;
  ufc_cnt_t  count;
  modport store (input push, wdata, pop, flush, output rdata, count);
  modport user  (output push, wdata, pop, flush, input rdata, count);
endinterface
`default_nettype wire

// ==== logic/ufc_fifo.sv ====
// Purpose: 16-entry byte fifo held in flip-flops
// Assumes: flush has priority over push and pop
// Notes: rdata shows the head entry
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.svh"
module ufc_fifo
  import ufc_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // queue port
  ufc_fifo_if.store q
);
  ufc_byte_t  mem_r [0:`UFC_DEPTH-1];
  logic [3:0] wp_r;
  logic [3:0] rp_r;
  ufc_cnt_t   cnt_r;
  logic       do_push;
  logic       do_pop;

  // accept only what fits or exists
  assign do_push = q.push && (cnt_r != `UFC_DEPTH);
  assign do_pop  = q.pop && (cnt_r != 5'h00);

  // storage, addressed by the write index
  always_ff @(posedge pclk) begin
    if (ce && do_push && !q.flush) begin
      mem_r[wp_r] <= q.wdata;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= 4'h0;
      rp_r  <= 4'h0;
      cnt_r <= 5'h00;
    end else if (ce) begin
      if (q.flush) begin
        wp_r  <= 4'h0;
        rp_r  <= 4'h0;
        cnt_r <= 5'h00;
      end else begin
        if (do_push) wp_r <= wp_r + 4'h1;
        if (do_pop) rp_r <= rp_r + 4'h1;
        cnt_r <= cnt_r + {4'h0, do_push} - {4'h0, do_pop};
      end
    end
  end

  assign q.rdata = mem_r[rp_r];
  assign q.count = cnt_r;

  a_flush_empties: assert property (@(posedge pclk) disable iff (!presetn)
    ce && q.flush |=> cnt_r == 5'h00)
    else $error("flush left entries in fifo");
endmodule
`default_nettype wire

// ==== logic/ufc_apb.sv ====
// Purpose: apb slave timing for the control registers
// Assumes: one wait state, answer in the second access cycle
// Notes: unmapped addresses answer with pslverr and zero data
`timescale 1ns/1ps
`default_nettype none
module ufc_apb (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // core side
  input  wire logic [31:0] rd_data,
  input  wire logic        map_ok,
  output logic             wr_stb,
  output logic             rd_stb
);
  logic first;

  // first access cycle captures the answer
  assign first = psel && penable && !pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= first;
      pslverr <= first && !map_ok;
      if (first) prdata <= (!pwrite && map_ok) ? rd_data : 32'h0000_0000;
    end
  end

  // completion strobes, at the edge that samples pready high
  assign wr_stb = ce && psel && penable && pready && pwrite && map_ok;
  assign rd_stb = ce && psel && penable && pready && !pwrite && map_ok;
endmodule
`default_nettype wire

// ==== tb/ufc_shifter_model.sv ====
// Purpose: serial shifter side seen by the fifo control block
// Assumes: shares pclk with the block, driven by bench tasks
// Notes: data lines carry the inverse of the last byte when idle
`timescale 1ns/1ps
`default_nettype none
module ufc_shifter_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // transmit side
  input  wire logic       tx_avail,
  input  wire logic [7:0] tx_data,
  output logic            tx_take,
  output logic            tx_shift_empty,
  // receive side
  output logic            rx_push,
  output logic [7:0]      rx_data,
  output logic [2:0]      rx_err,
  output logic            rx_timeout
);
  logic       take_en;
  logic [2:0] busy;
  logic [7:0] last_tx;

  // idle receive lines at time zero
  initial begin
    take_en    = 1'b0;
    rx_push    = 1'b0;
    rx_data    = 8'h00;
    rx_err     = 3'h0;
    rx_timeout = 1'b0; // timeout comes from here
  end

  // take offered bytes while enabled, stay busy shifting for a while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_take <= 1'b0;
      busy    <= 3'h0;
      last_tx <= 8'h00;
    end else begin
      tx_take <= take_en && tx_avail && !tx_take;
      if (tx_take && tx_avail) begin
        busy    <= 3'h7;
        last_tx <= tx_data;
      end else if (busy != 3'h0) begin
        busy <= busy - 3'h1;
      end
    end
  end

  assign tx_shift_empty = (busy == 3'h0);

  // deliver one received character with its error flags
  task automatic send(input logic [7:0] b, input logic [2:0] e);
    @(posedge pclk);
    rx_push <= 1'b1;
    rx_data <= b;
    rx_err  <= e;
    @(posedge pclk);
    rx_push <= 1'b0;
    rx_data <= ~b;
    rx_err  <= ~e;
  endtask
endmodule
`default_nettype wire

// ==== tb/ufc_top_tb_top.sv ====
// Purpose: self-checking bench for the uart fifo control block
// Assumes: apb register map and one-cycle output lag of the block
// Notes: ce is dropped once near the end to show that it freezes the block
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.svh"
module ufc_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rx_push, rx_timeout, tx_take, tx_empty, tx_avail;
  logic [7:0]  rx_data, tx_data;
  logic [2:0]  rx_err;
  logic        txn, rxn, irq, ce;
  int          n_errors, checks;
  int          lvl [4] = '{1, 4, 8, 14};

  ufc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_push(rx_push), .rx_data(rx_data), .rx_err(rx_err),
    .rx_timeout(rx_timeout), .tx_take(tx_take),
    .tx_shift_empty(tx_empty), .tx_data(tx_data), .tx_avail(tx_avail),
    .tx_dma_request_n(txn), .rx_dma_request_n(rxn), .irq(irq));

  ufc_shifter_model sh (.pclk(pclk), .presetn(presetn),
    .tx_avail(tx_avail), .tx_data(tx_data), .tx_take(tx_take),
    .tx_shift_empty(tx_empty), .rx_push(rx_push), .rx_data(rx_data),
    .rx_err(rx_err), .rx_timeout(rx_timeout));

  // 100 MHz clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic finish_test();
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic w8(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // watchdog against a hung handshake
  initial begin
    #300us;
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    n_errors = 0;
    checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    presetn = 1'b0;
    w8(6);
    presetn <= 1'b1;
    w8(1);
    chk(32'(txn), 32'h0000_0001 ^ 32'h0000_0001);
    chk(32'(rxn), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    rdc(`UFC_OFF_IE, 32'h0000_0000);
    rdc(`UFC_OFF_FC, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    wr(`UFC_OFF_FC, 32'h0000_00C8);
    rdc(`UFC_OFF_FC, 32'h0000_0000);
    // each trigger code: interrupt at the level, gone below it
    for (int c = 0; c < 4; c++) begin
      wr(`UFC_OFF_FC, {24'h00_0000, 2'(c), 6'h07});
      wr(`UFC_OFF_IE, 32'h0000_0001);
      rdc(`UFC_OFF_FC, {24'h00_0000, 2'(c), 6'h01});
      for (int k = 0; k < lvl[c] - 1; k++) sh.send(8'(k), 3'h0);
      w8(2);
      chk(32'(irq), 32'h0000_0000);
      sh.send(8'hA5, 3'h0);
      w8(2);
      chk(32'(irq), 32'h0000_0001);
      rdc(`UFC_OFF_IS, 32'h0000_00C4);
      apb(1'b0, `UFC_OFF_DATA, 32'h0000_0000);
      w8(2);
      chk(32'(irq), 32'h0000_0000);
      rdc(`UFC_OFF_IS, 32'h0000_00C1);
    end
    // polled mode: fill past the trigger to full, drain in order
    wr(`UFC_OFF_FC, 32'h0000_0047);
    wr(`UFC_OFF_IE, 32'h0000_0000);
    for (int k = 0; k < 16; k++) sh.send(8'h10 + 8'(k), 3'h0);
    w8(2);
    rdc(`UFC_OFF_LS, 32'h0000_0061);
    for (int k = 0; k < 16; k++)
      rdc(`UFC_OFF_DATA, 32'h0000_0010 + k);
    w8(2);
    rdc(`UFC_OFF_LS, 32'h0000_0060);
    // block mode receive request and timeout
    wr(`UFC_OFF_FC, 32'h0000_004F);
    rdc(`UFC_OFF_FC, 32'h0000_0049);
    for (int k = 0; k < 3; k++) sh.send(8'(k), 3'h0);
    w8(2);
    chk(32'(rxn), 32'h0000_0001);
    sh.send(8'h03, 3'h0);
    w8(2);
    chk(32'(rxn), 32'h0000_0000);
    for (int k = 0; k < 3; k++) apb(1'b0, `UFC_OFF_DATA, 32'h0000_0000);
    w8(2);
    chk(32'(rxn), 32'h0000_0000);
    apb(1'b0, `UFC_OFF_DATA, 32'h0000_0000);
    w8(2);
    chk(32'(rxn), 32'h0000_0001);
    sh.send(8'h77, 3'h0);
    sh.rx_timeout <= 1'b1;
    wr(`UFC_OFF_IE, 32'h0000_0001);
    w8(2);
    chk({30'h0, rxn, irq}, 32'h0000_0001);
    rdc(`UFC_OFF_IS, 32'h0000_00CC);
    sh.rx_timeout <= 1'b0;
    wr(`UFC_OFF_IE, 32'h0000_0000);
    apb(1'b0, `UFC_OFF_DATA, 32'h0000_0000);
    w8(2);
    chk(32'(rxn), 32'h0000_0001);
    // block mode transmit request, then transmit flush
    for (int k = 0; k < 15; k++) wr(`UFC_OFF_DATA, 32'(k));
    w8(2);
    chk(32'(txn), 32'h0000_0000);
    wr(`UFC_OFF_DATA, 32'h0000_000F);
    w8(2);
    chk(32'(txn), 32'h0000_0001);
    rdc(`UFC_OFF_LS, 32'h0000_0000);
    wr(`UFC_OFF_FC, 32'h0000_000D);
    w8(2);
    chk(32'(txn), 32'h0000_0000);
    rdc(`UFC_OFF_LS, 32'h0000_0060);
    // single mode, fifos off: transmit request and holding empty irq
    wr(`UFC_OFF_FC, 32'h0000_0000);
    wr(`UFC_OFF_IE, 32'h0000_0002);
    w8(2);
    chk(32'(irq), 32'h0000_0001);
    wr(`UFC_OFF_DATA, 32'h0000_005A);
    w8(2);
    chk({30'h0, txn, irq}, 32'h0000_0002);
    sh.take_en <= 1'b1;
    for (int n = 0; n < 40 && sh.busy == 3'h0; n++) w8(1);
    w8(2);
    chk({30'h0, txn, irq}, 32'h0000_0001);
    rdc(`UFC_OFF_LS, 32'h0000_0020);
    for (int n = 0; n < 40 && sh.busy != 3'h0; n++) w8(1);
    w8(2);
    rdc(`UFC_OFF_LS, 32'h0000_0060);
    chk(32'(sh.last_tx), 32'h0000_005A);
    // line status interrupt and error bits
    wr(`UFC_OFF_IE, 32'h0000_0004);
    sh.send(8'h33, 3'h1);
    w8(2);
    chk({30'h0, rxn, irq}, 32'h0000_0001);
    rdc(`UFC_OFF_LS, 32'h0000_0065);
    w8(2);
    chk(32'(irq), 32'h0000_0000);
    rdc(`UFC_OFF_DATA, 32'h0000_0033);
    w8(2);
    chk(32'(rxn), 32'h0000_0001);
    wr(`UFC_OFF_FC, 32'h0000_0007);
    sh.send(8'h44, 3'h4);
    w8(2);
    rdc(`UFC_OFF_LS, 32'h0000_00F1);
    // clock enable low: an arrival in that time is not taken
    ce <= 1'b0;
    sh.send(8'h55, 3'h0);
    ce <= 1'b1;
    rdc(`UFC_OFF_DATA, 32'h0000_0044);
    rdc(`UFC_OFF_LS, 32'h0000_0060);
    finish_test();
  end
endmodule
`default_nettype wire
